/* File: hw/sig_pkg.sv */
package sig_pkg;
	// ----------------------------------------
	// clock source selections
	// ----------------------------------------
	localparam logic [1:0] SEL_OTHER = 2'h0;
	localparam logic [1:0] SEL_SUBCLK = 2'h1;
	localparam logic [1:0] SEL_RING = 2'h2;
	localparam logic [1:0] SEL_EXTCLK = 2'h3;
	localparam int NUM_CSI = 2;
	localparam int NUM_UART = 3;
	localparam int NUM_TM8 = 2;
	localparam int PORT_W = 8;
	localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
	typedef enum logic [1:0] {
		DAC_IDLE,
		DAC_CONV,
		DAC_HOLD
	} sig_dac_type;
endpackage

/* File: hw/sig_sync_if.sv */
`timescale 1ns/1ps
interface sig_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport src(output raw, input synced);
	modport dst(input raw, output synced);
endinterface

/* File: hw/sig_sync.sv */
`timescale 1ns/1ps
module sig_sync
	import sig_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset_n,
	sig_sync_if.dst s
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] out_r;
	logic [W-1:0] out_nxt;
	always_comb begin
		meta_nxt = s.raw;
		out_nxt = meta_r;
		if (!reset_n) begin
			meta_nxt = '0;
			out_nxt = '0;
		end
	end
	always_ff @(posedge clk) begin
		meta_r <= meta_nxt;
		out_r <= out_nxt;
	end
	assign s.synced = out_r;
endmodule

/* File: hw/sig_sub_idle_gating.sv */
`timescale 1ns/1ps
// Behaviour
// - sub-idle: watch timer counts only with subclock as count clock
// - sub-idle: second watchdog counts only with ring oscillator clock selected
// - clocked serial: stop if main osc runs; run on external clock if stopped
// - async ch0 runs only on external baud clock; other async channels stop
// - dac channel 0 stops in sub-idle and holds its last output
// - conversion in progress at entry completes, then its result is held
// - real-time output runs only if its trigger is an 8-bit timer that keeps running
// - port levels and directions held as at sub-idle entry
// - internal storage keeps its values throughout sub-idle
module sig_sub_idle_gating
	import sig_pkg::*;
#(
	parameter int PW = PORT_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic subIdle,
	input wire logic mainOscRunning,
	input wire logic [1:0] watchClkSel,
	input wire logic [1:0] wdt2ClkSel,
	input wire logic [1:0] clockedSerialClkSel0,
	input wire logic [1:0] clockedSerialClkSel1,
	input wire logic [1:0] asyncSerialClkSel0,
	input wire logic [1:0] timer8ClkSel0,
	input wire logic [1:0] timer8ClkSel1,
	input wire logic rtoTrigIsTimer8,
	input wire logic rtoTrigSel,
	input wire logic dacConvBusy,
	input wire logic [PW-1:0] portLevel,
	input wire logic [PW-1:0] portDir,
	output logic watchEn_r,
	output logic wdt2En_r,
	output logic [NUM_CSI-1:0] clockedSerialEn_r,
	output logic [NUM_UART-1:0] asyncSerialEn_r,
	output logic [NUM_TM8-1:0] timer8En_r,
	output logic dac0En_r,
	output logic dac0Hold_r,
	output logic rtoEn_r,
	output logic [PW-1:0] portLevelOut_r,
	output logic [PW-1:0] portDirOut_r,
	output logic storageHold_r
);
	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	sig_sync_if #(.W(2)) syn();
	logic idleS;
	logic oscS;
	assign syn.raw = {subIdle, mainOscRunning};
	assign idleS = syn.synced[1];
	assign oscS = syn.synced[0];
	sig_sync #(.W(2)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.s(syn)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic runIf(input logic idle, input logic [1:0] sel,
		input logic [1:0] want);
		runIf = !idle || (sel == want);
	endfunction

	// ----------------------------------------
	// enables
	// ----------------------------------------
	logic watchEn_nxt;
	logic wdt2En_nxt;
	logic [NUM_CSI-1:0] clockedSerialEn_nxt;
	logic [NUM_UART-1:0] asyncSerialEn_nxt;
	logic [NUM_TM8-1:0] timer8En_nxt;
	logic rtoEn_nxt;
	logic storageHold_nxt;
	logic [PW-1:0] portLevelOut_nxt;
	logic [PW-1:0] portDirOut_nxt;
	always_comb begin
		watchEn_nxt = runIf(idleS, watchClkSel, SEL_SUBCLK);
		wdt2En_nxt = runIf(idleS, wdt2ClkSel, SEL_RING);
		clockedSerialEn_nxt[0] = !idleS
			|| (!oscS && clockedSerialClkSel0 == SEL_EXTCLK);
		clockedSerialEn_nxt[1] = !idleS
			|| (!oscS && clockedSerialClkSel1 == SEL_EXTCLK);
		asyncSerialEn_nxt = {NUM_UART{!idleS}};
		asyncSerialEn_nxt[0] = runIf(idleS, asyncSerialClkSel0, SEL_EXTCLK);
		timer8En_nxt[0] = runIf(idleS, timer8ClkSel0, SEL_EXTCLK);
		timer8En_nxt[1] = runIf(idleS, timer8ClkSel1, SEL_EXTCLK);
		rtoEn_nxt = !idleS || (rtoTrigIsTimer8 && timer8En_nxt[rtoTrigSel]);
		storageHold_nxt = idleS;
		portLevelOut_nxt = idleS ? portLevelOut_r : portLevel;
		portDirOut_nxt = idleS ? portDirOut_r : portDir;
		if (!reset_n) begin
			watchEn_nxt = 1'h1;
			wdt2En_nxt = 1'h1;
			clockedSerialEn_nxt = '1;
			asyncSerialEn_nxt = '1;
			timer8En_nxt = '1;
			rtoEn_nxt = 1'h1;
			storageHold_nxt = 1'h0;
			portLevelOut_nxt = PW'(PORT_RST);
			portDirOut_nxt = PW'(PORT_RST);
		end
	end
	always_ff @(posedge clk) begin
		watchEn_r <= watchEn_nxt;
		wdt2En_r <= wdt2En_nxt;
		clockedSerialEn_r <= clockedSerialEn_nxt;
		asyncSerialEn_r <= asyncSerialEn_nxt;
		timer8En_r <= timer8En_nxt;
		rtoEn_r <= rtoEn_nxt;
		storageHold_r <= storageHold_nxt;
		portLevelOut_r <= portLevelOut_nxt;
		portDirOut_r <= portDirOut_nxt;
	end

	// ----------------------------------------
	// dac channel 0
	// ----------------------------------------
	sig_dac_type dacState_r;
	sig_dac_type dacState_nxt;
	logic dac0En_nxt;
	logic dac0Hold_nxt;
	always_comb begin
		dacState_nxt = dacState_r;
		case (dacState_r)
			DAC_IDLE: begin
				if (idleS) begin
					dacState_nxt = dacConvBusy ? DAC_CONV : DAC_HOLD;
				end
			end
			DAC_CONV: begin
				if (!idleS) begin
					dacState_nxt = DAC_IDLE;
				end else if (!dacConvBusy) begin
					dacState_nxt = DAC_HOLD;
				end
			end
			DAC_HOLD: begin
				if (!idleS) begin
					dacState_nxt = DAC_IDLE;
				end
			end
			default: dacState_nxt = DAC_IDLE;
		endcase
		dac0En_nxt = (dacState_nxt != DAC_HOLD);
		dac0Hold_nxt = (dacState_nxt == DAC_HOLD);
		if (!reset_n) begin
			dacState_nxt = DAC_IDLE;
			dac0En_nxt = 1'h1;
			dac0Hold_nxt = 1'h0;
		end
	end
	always_ff @(posedge clk) begin
		dacState_r <= dacState_nxt;
		dac0En_r <= dac0En_nxt;
		dac0Hold_r <= dac0Hold_nxt;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	watch_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && watchClkSel != SEL_SUBCLK) |=> !watchEn_r)
		else $error("watch timer runs with wrong clock in sub-idle");
	wdt2_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && wdt2ClkSel != SEL_RING) |=> !wdt2En_r)
		else $error("second watchdog runs with wrong clock in sub-idle");
	csi_osc_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && oscS) |=> clockedSerialEn_r == '0)
		else $error("clocked serial runs while main osc runs in sub-idle");
	csi_ext_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && !oscS && clockedSerialClkSel0 == SEL_EXTCLK) |=> clockedSerialEn_r[0])
		else $error("clocked serial 0 stopped with external clock");
	uart_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
		idleS |=> asyncSerialEn_r[2:1] == 2'h0
		&& asyncSerialEn_r[0] == ($past(asyncSerialClkSel0) == SEL_EXTCLK))
		else $error("async serial gating wrong in sub-idle");
	dac_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && !dacConvBusy && dacState_r == DAC_IDLE) |=> dac0Hold_r && !dac0En_r)
		else $error("dac not held in sub-idle");
	dac_finish_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && dacConvBusy && dacState_r == DAC_IDLE) |=> dac0En_r ##0 !dac0Hold_r)
		else $error("dac conversion cut short");
	rto_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && !rtoTrigIsTimer8) |=> !rtoEn_r)
		else $error("real-time output runs without timer trigger");
	port_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && $past(idleS)) |-> $stable(portLevelOut_r) && $stable(portDirOut_r))
		else $error("port state changed in sub-idle");
	storage_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		idleS |=> storageHold_r)
		else $error("storage hold missing in sub-idle");
	watch_run_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && watchClkSel == SEL_SUBCLK) |=> watchEn_r)
		else $error("watch timer stopped with subclock in sub-idle");
	wdt2_run_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && wdt2ClkSel == SEL_RING) |=> wdt2En_r)
		else $error("second watchdog stopped with ring clock in sub-idle");
	csi_ext1_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && !oscS && clockedSerialClkSel1 == SEL_EXTCLK) |=> clockedSerialEn_r[1])
		else $error("clocked serial 1 stopped with external clock");
	csi_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && clockedSerialClkSel1 != SEL_EXTCLK) |=> !clockedSerialEn_r[1])
		else $error("clocked serial 1 runs without external clock");
	dac_held_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && dac0Hold_r) |=> dac0Hold_r && !dac0En_r)
		else $error("dac hold lost in sub-idle");
	rto_run_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && rtoTrigIsTimer8 && !rtoTrigSel && timer8ClkSel0 == SEL_EXTCLK) |=> rtoEn_r)
		else $error("real-time output stopped with running timer 0 trigger");
	rto_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
		(idleS && rtoTrigSel && timer8ClkSel1 != SEL_EXTCLK) |=> !rtoEn_r)
		else $error("real-time output runs with stopped timer 1 trigger");
	port_track_a: assert property (@(posedge clk) disable iff (!reset_n)
		!idleS |=> portLevelOut_r == $past(portLevel) && portDirOut_r == $past(portDir))
		else $error("port state not tracked outside sub-idle");
	storage_free_a: assert property (@(posedge clk) disable iff (!reset_n)
		!idleS |=> !storageHold_r)
		else $error("storage held outside sub-idle");
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
	import sig_pkg::*;
	logic clk = 1'h0;
	logic reset_n = 1'h0;
	logic subIdle = 1'h0;
	logic mainOscRunning = 1'h1;
	logic [1:0] watchClkSel = SEL_OTHER;
	logic [1:0] wdt2ClkSel = SEL_OTHER;
	logic [1:0] clockedSerialClkSel0 = SEL_OTHER;
	logic [1:0] clockedSerialClkSel1 = SEL_OTHER;
	logic [1:0] asyncSerialClkSel0 = SEL_OTHER;
	logic [1:0] timer8ClkSel0 = SEL_OTHER;
	logic [1:0] timer8ClkSel1 = SEL_OTHER;
	logic rtoTrigIsTimer8 = 1'h0;
	logic rtoTrigSel = 1'h0;
	logic dacConvBusy = 1'h0;
	logic [7:0] portLevel = 8'h00;
	logic [7:0] portDir = 8'h00;
	logic watchEn_r, wdt2En_r, dac0En_r, dac0Hold_r, rtoEn_r, storageHold_r;
	logic [1:0] clockedSerialEn_r;
	logic [2:0] asyncSerialEn_r;
	logic [1:0] timer8En_r;
	logic [7:0] portLevelOut_r, portDirOut_r;
	logic [9:0] en;
	int mismatches = 0;
	int totalChecks = 0;
	int cycles = 0;
	assign en = {watchEn_r, wdt2En_r, clockedSerialEn_r, asyncSerialEn_r, timer8En_r, rtoEn_r};
	sig_sub_idle_gating DUT (.clk, .reset_n, .subIdle, .mainOscRunning, .watchClkSel,
		.wdt2ClkSel, .clockedSerialClkSel0, .clockedSerialClkSel1, .asyncSerialClkSel0,
		.timer8ClkSel0, .timer8ClkSel1, .rtoTrigIsTimer8, .rtoTrigSel, .dacConvBusy,
		.portLevel, .portDir, .watchEn_r, .wdt2En_r, .clockedSerialEn_r, .asyncSerialEn_r,
		.timer8En_r, .dac0En_r, .dac0Hold_r, .rtoEn_r, .portLevelOut_r, .portDirOut_r,
		.storageHold_r);
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	task automatic chk(string nm, logic [9:0] seen, logic [9:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic settle();
		repeat (5) @(negedge clk);
	endtask
	task automatic tally_and_finish();
		if (mismatches == 0 && totalChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic t_awake();
		portLevel = 8'hA5;
		portDir = 8'h5A;
		settle();
		chk("enables", en, 10'h3FF);
		chk("level", {2'h0, portLevelOut_r}, 10'h0A5);
		chk("storage", {9'h0, storageHold_r}, 10'h000);
	endtask
	task automatic t_osc_run();
		portLevel = 8'h3C;
		portDir = 8'hC3;
		clockedSerialClkSel0 = SEL_EXTCLK;
		clockedSerialClkSel1 = SEL_EXTCLK;
		subIdle = 1'h1;
		settle();
		portLevel = 8'h00;
		portDir = 8'hFF;
		settle();
		chk("enables", en, 10'h000);
		chk("level", {2'h0, portLevelOut_r}, 10'h03C);
		chk("dir", {2'h0, portDirOut_r}, 10'h0C3);
		chk("storage", {9'h0, storageHold_r}, 10'h001);
		chk("dac", {8'h0, dac0En_r, dac0Hold_r}, 10'h001);
		subIdle = 1'h0;
		settle();
		chk("enables", en, 10'h3FF);
		chk("dir", {2'h0, portDirOut_r}, 10'h0FF);
	endtask
	task automatic t_osc_stop();
		mainOscRunning = 1'h0;
		watchClkSel = SEL_SUBCLK;
		wdt2ClkSel = SEL_RING;
		asyncSerialClkSel0 = SEL_EXTCLK;
		timer8ClkSel0 = SEL_EXTCLK;
		rtoTrigIsTimer8 = 1'h1;
		subIdle = 1'h1;
		settle();
		chk("enables", en, 10'h3CB);
		rtoTrigSel = 1'h1;
		settle();
		chk("rto", {9'h0, rtoEn_r}, 10'h000);
		timer8ClkSel1 = SEL_EXTCLK;
		settle();
		chk("rto", {9'h0, rtoEn_r}, 10'h001);
		chk("timer8", {8'h0, timer8En_r}, 10'h003);
		clockedSerialClkSel1 = SEL_OTHER;
		settle();
		chk("serial", {8'h0, clockedSerialEn_r}, 10'h001);
		mainOscRunning = 1'h1;
		settle();
		chk("serial", {8'h0, clockedSerialEn_r}, 10'h000);
		subIdle = 1'h0;
		settle();
	endtask
	task automatic t_dac();
		dacConvBusy = 1'h1;
		subIdle = 1'h1;
		settle();
		chk("dac", {8'h0, dac0En_r, dac0Hold_r}, 10'h002);
		dacConvBusy = 1'h0;
		settle();
		chk("dac", {8'h0, dac0En_r, dac0Hold_r}, 10'h001);
		subIdle = 1'h0;
		settle();
	endtask
	task automatic t_reset();
		portLevel = 8'h77;
		portDir = 8'h88;
		subIdle = 1'h1;
		settle();
		chk("enables", en, 10'h30F);
		reset_n = 1'h0;
		repeat (2) @(negedge clk);
		chk("enables", en, 10'h3FF);
		chk("level", {2'h0, portLevelOut_r}, 10'h000);
		chk("storage", {9'h0, storageHold_r}, 10'h000);
		chk("dac", {8'h0, dac0En_r, dac0Hold_r}, 10'h002);
		reset_n = 1'h1;
		@(negedge clk);
		chk("enables", en, 10'h3FF);
		chk("level", {2'h0, portLevelOut_r}, 10'h077);
		settle();
		chk("dir", {2'h0, portDirOut_r}, 10'h088);
		chk("storage", {9'h0, storageHold_r}, 10'h001);
		chk("dac", {8'h0, dac0En_r, dac0Hold_r}, 10'h001);
		subIdle = 1'h0;
		settle();
	endtask
	initial begin
		repeat (8) @(negedge clk);
		reset_n = 1'h1;
		t_awake();
		t_osc_run();
		t_osc_stop();
		t_dac();
		t_reset();
		tally_and_finish();
	end
endmodule
